// file: spc_checker.sv
// Stream pattern checker top: sink, comparator, counters, Wishbone slave
//
// Local design decision: register access over Wishbone.
`include "spc_map.svh"
module spc_checker #(
  parameter int stream_word_width = 40,
  parameter int LOCK_RUN = `SPC_LOCK_RUN,
  parameter int UNLOCK_RUN = `SPC_UNLOCK_RUN
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic snk_valid_i,
  input wire logic [stream_word_width-1:0] snk_data_i,
  output logic snk_ready_o,
  output logic lock_indicator_o
);
  localparam int W = stream_word_width;

  // ==========================================================
  // Elaboration checks
  if (W != 32 && W != 40) begin : g_bad_width
    $error("stream_word_width must be 32 or 40");
  end
  if (LOCK_RUN < 1 || LOCK_RUN > 15) begin : g_bad_lock
    $error("LOCK_RUN must lie in 1..15");
  end
  if (UNLOCK_RUN < 1 || UNLOCK_RUN > 15) begin : g_bad_unlock
    $error("UNLOCK_RUN must lie in 1..15");
  end

  localparam logic [3:0] LOCK_LAST = 4'(LOCK_RUN - 1);
  localparam logic [3:0] UNLOCK_LAST = 4'(UNLOCK_RUN - 1);
  localparam logic [63:0] WORD_BITS = 64'(W);

  // ==========================================================
  // Declarations
  logic enable_q;
  spc_pkg::spc_sel_type sel_q;
  logic clear_q;
  logic ready_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [63:0] bits_q;
  logic [63:0] errs_q;
  logic [63:0] bits_snap_q;
  logic [63:0] errs_snap_q;
  logic [30:0] hist_q;
  spc_pkg::spc_lock_type lock_st_q;
  spc_pkg::spc_lock_type lock_st_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic lock_q;

  logic bus_req;
  logic bus_wr;
  logic addr_ok;
  logic [2:0] reg_idx;
  logic wr_status;
  logic wr_select;
  logic wr_ctrl;
  logic snap_req;
  logic clr_req;
  logic dis_req;
  logic beat;
  logic check_beat;
  logic word_bad;
  logic [31:0] rd_mux;

  spc_cmp_if #(.W(W)) cmp_bus ();

  // ==========================================================
  // Comparator
  assign cmp_bus.data = snk_data_i;
  assign cmp_bus.hist = hist_q;
  assign cmp_bus.sel = sel_q;

  spc_ref_cmp #(
    .W(W)
  ) spc_ref_cmp_i (
    .cif(cmp_bus)
  );

  // ==========================================================
  // Wishbone decode
  // Registers sit on word addresses; the low two address bits are
  // ignored and anything past index 6 answers with zero data.
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i;
  assign reg_idx = wb_adr_i[4:2];
  assign addr_ok = (wb_adr_i[7:5] == 3'h0) && (reg_idx <= `SPC_IDX_ERR_HI);
  assign wr_status = bus_wr && addr_ok && (reg_idx == `SPC_IDX_STATUS);
  assign wr_select = bus_wr && addr_ok && (reg_idx == `SPC_IDX_SELECT);
  assign wr_ctrl = bus_wr && addr_ok && (reg_idx == `SPC_IDX_CTRL);
  assign snap_req = wr_ctrl && wb_sel_i[0] &&
                    wb_dat_i[`SPC_CTRL_SNAP_BIT];
  assign clr_req = wr_ctrl && wb_sel_i[2] &&
                   wb_dat_i[`SPC_CTRL_CLR_BIT];
  // Disabling drops lock at the write edge, together with the state
  assign dis_req = wr_status && wb_sel_i[0] &&
                   !wb_dat_i[`SPC_STATUS_EN_BIT];

  // ==========================================================
  // Stream sink
  // The checker never needs to stall the source, so ready stays high
  // from the first edge after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= 1'b1;
    end
  end

  assign beat = snk_valid_i & ready_q;
  assign check_beat = beat & enable_q;
  assign word_bad = (cmp_bus.err_bits != '0);

  // History follows accepted words only while checking runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_q <= '0;
    end else if (check_beat) begin
      hist_q <= cmp_bus.hist_next;
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_q <= 1'b0;
    end else if (wr_status && wb_sel_i[0]) begin
      enable_q <= wb_dat_i[`SPC_STATUS_EN_BIT];
    end
  end

  // Frozen while checking runs so the reference cannot jump mid-stream
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q <= `SPC_SEL_RESET;
    end else if (wr_select && wb_sel_i[0] && !enable_q) begin
      sel_q <= wb_dat_i[`SPC_SEL_W-1:0];
    end
  end

  // Clear stays up for one cycle and then drops by itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_q <= 1'b0;
    end else begin
      clear_q <= clr_req;
    end
  end

  // ==========================================================
  // Internal counters
  // Enable does not touch them, so a pause keeps the running totals.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits_q <= '0;
    end else if (clr_req) begin
      bits_q <= '0;
    end else if (check_beat) begin
      bits_q <= bits_q + WORD_BITS;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      errs_q <= '0;
    end else if (clr_req) begin
      errs_q <= '0;
    end else if (check_beat) begin
      errs_q <= errs_q + {58'h0, cmp_bus.err_bits};
    end
  end

  // ==========================================================
  // Snapshots
  // The copy is the counter value before the write edge; a beat in the
  // same cycle lands in the counter and shows in the next snapshot.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits_snap_q <= '0;
    end else if (clr_req) begin
      bits_snap_q <= '0;
    end else if (snap_req) begin
      bits_snap_q <= bits_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      errs_snap_q <= '0;
    end else if (clr_req) begin
      errs_snap_q <= '0;
    end else if (snap_req) begin
      errs_snap_q <= errs_q;
    end
  end

  // ==========================================================
  // Lock tracking
  // With UNLOCK_RUN above 1 a single bad word only moves to slip; lock is lost
  // once errors last for a whole run, so one bit flip does not drop it.
  always_comb begin
    lock_st_d = lock_st_q;
    run_d = run_q;
    if (!enable_q) begin
      lock_st_d = spc_pkg::spc_hunt;
      run_d = '0;
    end else if (check_beat) begin
      unique case (lock_st_q)
        spc_pkg::spc_hunt: begin
          if (word_bad) begin
            run_d = '0;
          end else if (run_q == LOCK_LAST) begin
            lock_st_d = spc_pkg::spc_locked;
            run_d = '0;
          end else begin
            run_d = run_q + 4'h1;
          end
        end
        spc_pkg::spc_locked: begin
          run_d = '0;
          if (word_bad) begin
            lock_st_d = UNLOCK_RUN == 1 ? spc_pkg::spc_hunt
                                        : spc_pkg::spc_slip;
            run_d = 4'h1;
          end
        end
        spc_pkg::spc_slip: begin
          if (!word_bad) begin
            lock_st_d = spc_pkg::spc_locked;
            run_d = '0;
          end else if (run_q == UNLOCK_LAST) begin
            lock_st_d = spc_pkg::spc_hunt;
            run_d = '0;
          end else begin
            run_d = run_q + 4'h1;
          end
        end
        default: begin
          lock_st_d = spc_pkg::spc_hunt;
          run_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_st_q <= spc_pkg::spc_hunt;
      run_q <= '0;
    end else if (clr_req || dis_req) begin
      lock_st_q <= spc_pkg::spc_hunt;
      run_q <= '0;
    end else begin
      lock_st_q <= lock_st_d;
      run_q <= run_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (clr_req || dis_req) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= (lock_st_d != spc_pkg::spc_hunt);
    end
  end

  // ==========================================================
  // Read mux
  // Lock is read-only: writes reach lock_q only by clearing it on disable or counter clear.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_ok) begin
      unique case (reg_idx)
        `SPC_IDX_STATUS: begin
          rd_mux[`SPC_STATUS_EN_BIT] = enable_q;
          rd_mux[`SPC_STATUS_LOCK_BIT] = lock_q;
        end
        `SPC_IDX_SELECT: begin
          rd_mux[`SPC_SEL_W-1:0] = sel_q;
        end
        `SPC_IDX_CTRL: begin
          rd_mux[`SPC_CTRL_CLR_BIT] = clear_q;
        end
        `SPC_IDX_BITS_LO: begin
          rd_mux = bits_snap_q[31:0];
        end
        `SPC_IDX_BITS_HI: begin
          rd_mux = bits_snap_q[63:32];
        end
        `SPC_IDX_ERR_LO: begin
          rd_mux = errs_snap_q[31:0];
        end
        `SPC_IDX_ERR_HI: begin
          rd_mux = errs_snap_q[63:32];
        end
        default: begin
          rd_mux = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // Bus answer
  // Answer one cycle after the request; ack lasts one cycle so a
  // master that releases promptly never sees a double answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      rdata_q <= rd_mux;
    end else if (bus_req) begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;
  assign snk_ready_o = ready_q;
  assign lock_indicator_o = lock_q;
endmodule

// file: spc_checker_tb.sv
// Self-checking testbench for the stream pattern checker
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module spc_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int W = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0, run = 1'b0, inj = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [2:0] mode = 3'h0;
  logic [3:0] lanes = 4'hf, bsel = 4'hf;
  logic valid, ack, ready, lock;
  logic [W-1:0] data;
  logic [63:0] b0, e0, b1 = '0, e1 = '0;
  int bad_count = 0, n_compared = 0, cyc_n = 0;
  initial forever #5 clk_i = ~clk_i;
  spc_checker #(.stream_word_width(W)) spc_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(bsel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .snk_valid_i(valid),
    .snk_data_i(data), .snk_ready_o(ready), .lock_indicator_o(lock));
  spc_src #(.W(W)) spc_src_i (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .inj_i(inj), .mode_i(mode), .valid_o(valid), .data_o(data));
  // ========
  // Bus and stream tasks
  task automatic wb(input logic w, input logic [2:0] i,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {3'h0, i, 2'h0};
    wdat <= d;
    bsel <= lanes;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask
  task automatic rd_chk(input logic [2:0] i, input logic [31:0] x);
    logic [31:0] q;
    wb(1'b0, i, 32'h0, q);
    `CHK(q, x)
  endtask
  task automatic snap(output logic [63:0] b, output logic [63:0] e);
    wr(3'h2, 32'h1);
    wb(1'b0, 3'h3, 32'h0, b[31:0]);
    wb(1'b0, 3'h4, 32'h0, b[63:32]);
    wb(1'b0, 3'h5, 32'h0, e[31:0]);
    wb(1'b0, 3'h6, 32'h0, e[63:32]);
  endtask
  // Every word of a call carries the injected bit when x is set
  task automatic stream(input int n, input logic x);
    @(posedge clk_i);
    run <= 1'b1;
    inj <= x;
    repeat (n) @(posedge clk_i);
    run <= 1'b0;
    inj <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      bad_count++;
      summarize();
    end
  end
  // ========
  // Sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(i[2:0], (i == 1) ? 32'h1 : 32'h0);
    end
    wr(3'h0, 32'h2);
    rd_chk(3'h0, 32'h0);
    for (int m = 0; m < 6; m++) begin
      mode <= m[2:0];
      wr(3'h1, 32'h1 << m);
      rd_chk(3'h1, 32'h1 << m);
      wr(3'h0, 32'h1);
      snap(b0, e0);
      `CHK({b0, e0}, {b1, e1})
      wr(3'h1, 32'h2);
      rd_chk(3'h1, 32'h1 << m);
      stream(4, 1'b0);
      snap(b0, e0);
      stream(12, 1'b0);
      `CHK(lock, 1'b1)
      stream(4, 1'b1);
      `CHK(lock, 1'b0)
      stream(10, 1'b0);
      rd_chk(3'h0, 32'h3);
      wr(3'h0, 32'h0);
      stream(3, 1'b0);
      snap(b1, e1);
      `CHK(b1 - b0, 64'(26 * W))
      `CHK(e1 - e0, (m < 4) ? 64'h0c : 64'h04)
    end
    // Clear without its byte lane must leave the snapshot alone
    lanes = 4'hb;
    wr(3'h2, 32'h20000);
    lanes = 4'hf;
    rd_chk(3'h3, b1[31:0]);
    wr(3'h2, 32'h20000);
    rd_chk(3'h2, 32'h0);
    for (int i = 3; i < 7; i++) begin
      rd_chk(i[2:0], 32'h0);
    end
    snap(b0, e0);
    `CHK({b0, e0}, 128'h0)
    summarize();
  end
endmodule
bind spc_checker spc_chk #(.LOCK_RUN(LOCK_RUN)) spc_chk_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .snk_valid_i, .snk_ready_o, .lock_indicator_o);

// file: spc_chk_checker.sv
// Port-level assertions for the stream pattern checker
module spc_chk #(
  parameter int LOCK_RUN = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic snk_valid_i,
  input wire logic snk_ready_o,
  input wire logic lock_indicator_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req, wr, beat;
  logic [2:0] idx;
  logic [3:0] run_q;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i;
  assign idx = wb_adr_i[4:2];
  assign beat = snk_valid_i && snk_ready_o;
  // ========
  // Beats since lock state could last be forced back to hunt
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr && (idx == 3'h0 || (idx == 3'h2 && wb_dat_i[17])))) begin
      run_q <= 4'h0;
    end else if (beat && run_q != 4'hf) begin
      run_q <= run_q + 4'h1;
    end
  end
  // ========
  // Properties
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("no answer one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("answer held longer than one cycle");
  a_lock_readback: assert property ((req && !wb_we_i && idx == 3'h0)
    |=> wb_dat_o[1] == $past(lock_indicator_o))
    else $error("status lock bit differs from lock output");
  a_lock_clean_run: assert property ($rose(lock_indicator_o)
    |-> run_q >= LOCK_RUN)
    else $error("lock gained before a full clean run");
  a_lock_cause: assert property ($changed(lock_indicator_o)
    |-> $past(beat || wr))
    else $error("lock changed with no beat or write");
  a_clear_unlocks: assert property ((wr && idx == 3'h2 && wb_dat_i[17]
    && wb_sel_i[2]) |=> !lock_indicator_o)
    else $error("lock survived a counter clear");
  a_disable_unlocks: assert property ((wr && idx == 3'h0 && !wb_dat_i[0]
    && wb_sel_i[0]) |=> !lock_indicator_o)
    else $error("lock survived disabling");
  a_ctrl_reads_zero: assert property ((req && !wb_we_i
    && (idx == 3'h2 || idx == 3'h7)) |=> wb_dat_o == 32'h0)
    else $error("write-only or unmapped place read nonzero");
  a_ready_held: assert property (!$past(rst_i) |-> snk_ready_o)
    else $error("sink not ready outside reset");
  c_lock: cover property ($rose(lock_indicator_o));
  c_unlock: cover property ($fell(lock_indicator_o) && !$past(wr));
  c_clear: cover property (wr && idx == 3'h2 && wb_dat_i[17]);
endmodule

// file: spc_cmp_if.sv
// Link between checker control and its reference comparator
interface spc_cmp_if #(parameter int W = 40);
  logic [W-1:0] data;
  logic [30:0] hist;
  spc_pkg::spc_sel_type sel;
  spc_pkg::spc_errs_type err_bits;
  logic [30:0] hist_next;
  modport ctrl (output data, hist, sel, input err_bits, hist_next);
  modport cmp (input data, hist, sel, output err_bits, hist_next);
endinterface

// file: spc_map.svh
// Register map, field positions, reset values and counts of the checker
// Contract
// - Pattern comparison happens only while the check-enable bit is one.
// - Status bit 1 shows lock; writes to it do nothing.
// - While enabled only check-enable and counter control accept writes.
// - Select bit 0 compares against seven-stage sequence, taps 7 and 6.
// - Select bit 1 compares against fifteen-stage sequence, taps 15, 14.
// - Select bit 2 compares against 23-stage sequence, taps 23 and 18.
// - Select bit 3 compares against 31-stage sequence, taps 31 and 28.
// - Select bit 4 compares against alternating ones and zeros.
// - Select bit 5 compares against block word: half ones, half zeros.
// - Snapshot write copies both internal counters in that same cycle.
// - Snapshot still captures correct counts after checking is disabled.
// - Clear bit resets counters and statistics and self-clears afterwards.
// - Toggling enable keeps counts; only clear or reset zeroes them.
// - Bit count snapshot is 64 bits over two read-only words.
// - Error count snapshot is 64 bits over two read-only words.
// - All snapshot words clear on reset or on counter clear.
// - Stream word width is a build parameter, 32 or 40 only.
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Register indices; byte address is four times the index
`define SPC_IDX_STATUS 3'h0
`define SPC_IDX_SELECT 3'h1
`define SPC_IDX_CTRL 3'h2
`define SPC_IDX_BITS_LO 3'h3
`define SPC_IDX_BITS_HI 3'h4
`define SPC_IDX_ERR_LO 3'h5
`define SPC_IDX_ERR_HI 3'h6

`define SPC_STATUS_EN_BIT 0
`define SPC_STATUS_LOCK_BIT 1
`define SPC_CTRL_SNAP_BIT 0
`define SPC_CTRL_CLR_BIT 17
`define SPC_SEL_W 6
`define SPC_SEL_RESET 6'h01

// Sequence taps
`define SPC_P7_A 7
`define SPC_P7_B 6
`define SPC_P15_A 15
`define SPC_P15_B 14
`define SPC_P23_A 23
`define SPC_P23_B 18
`define SPC_P31_A 31
`define SPC_P31_B 28
`define SPC_HIST_W 31

// Lock statistics, counted in accepted words
`define SPC_LOCK_RUN 8
`define SPC_UNLOCK_RUN 4

`endif

// file: spc_pkg.sv
// Types shared by the stream pattern checker
package spc_pkg;
  typedef logic [5:0] spc_sel_type;
  typedef logic [5:0] spc_errs_type;
  // Gray codes along hunt -> locked -> slipping
  typedef enum logic [1:0] {
    spc_hunt = 2'b00,
    spc_locked = 2'b01,
    spc_slip = 2'b11
  } spc_lock_type;
endpackage

// file: spc_ref_cmp.sv
// Reference pattern builder and mismatch counter for one stream word
`include "spc_map.svh"
module spc_ref_cmp #(
  parameter int W = 40
) (
  spc_cmp_if.cmp cif
);
  localparam int HW = `SPC_HIST_W;
  localparam int GRP = (W == 40) ? 10 : 8;
  logic [W+HW-1:0] chain;
  logic [W-1:0] ref_word;
  logic [W-1:0] miss;

  // Bit 0 is oldest; history bit 30 is the newest bit already seen
  assign chain = {cif.data, cif.hist};
  assign cif.hist_next = chain[W+HW-1:W];

  // ==========================================================
  // Expected bit per position
  // Sequences predict each bit from the received bits before it, so the
  // check synchronises by itself and needs no seed.
  for (genvar i = 0; i < W; i++) begin : g_bit
    localparam int P = HW + i;
    localparam logic ALT = (i % 2 == 0) ? 1'b1 : 1'b0;
    localparam logic BLK = ((i % GRP) >= GRP / 2) ? 1'b1 : 1'b0;
    always_comb begin
      if (cif.sel[0]) begin
        ref_word[i] = chain[P-`SPC_P7_A] ^ chain[P-`SPC_P7_B];
      end else if (cif.sel[1]) begin
        ref_word[i] = chain[P-`SPC_P15_A] ^ chain[P-`SPC_P15_B];
      end else if (cif.sel[2]) begin
        ref_word[i] = chain[P-`SPC_P23_A] ^ chain[P-`SPC_P23_B];
      end else if (cif.sel[3]) begin
        ref_word[i] = chain[P-`SPC_P31_A] ^ chain[P-`SPC_P31_B];
      end else if (cif.sel[4]) begin
        ref_word[i] = ALT;
      end else begin
        ref_word[i] = BLK;
      end
    end
  end

  assign miss = cif.data ^ ref_word;

  // ==========================================================
  // Mismatch count
  always_comb begin
    cif.err_bits = '0;
    for (int k = 0; k < W; k++) begin
      cif.err_bits = cif.err_bits + {5'h00, miss[k]};
    end
  end
endmodule

// file: spc_src_model.sv
// Stream source model: sequences and fixed words with bit-0 injection
module spc_src #(
  parameter int W = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic inj_i,
  input wire logic [2:0] mode_i,
  output logic valid_o,
  output logic [W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TA[4] = '{7, 15, 23, 31};
  localparam int TB[4] = '{6, 14, 18, 28};
  localparam int G = (W == 40) ? 10 : 8;
  logic [30:0] h_q, h;
  logic [W-1:0] w;
  // ========
  // Next word, oldest bit in bit 0; h[0] is the newest bit
  always_comb begin
    h = h_q;
    for (int i = 0; i < W; i++) begin
      if (mode_i < 3'h4) begin
        w[i] = h[TA[mode_i] - 1] ^ h[TB[mode_i] - 1];
      end else if (mode_i == 3'h4) begin
        w[i] = (i % 2) == 0;
      end else begin
        w[i] = (i % G) >= G / 2;
      end
      h = {h[29:0], w[i]};
    end
  end
  // Idle data is inverted so a stale word can never pass for a fresh one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      h_q <= '1;
      valid_o <= 1'b0;
      data_o <= '0;
    end else if (run_i) begin
      h_q <= h;
      valid_o <= 1'b1;
      data_o <= {w[W-1:1], w[0] ^ inj_i};
    end else begin
      valid_o <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule
